//--- rtl/pss_pkg.sv
// Constants shared by the peripheral input source selector and its pin filter
//
// Notes on behaviour
// - Bits 11,10,9 pick fault 3,2,1: 0 package pin, 1 comparator C,B,A.
// - Three 3-bit fields pick PWM source 2,1,0; codes 101-111 reserved.
// - An input with a single source is wired to it permanently, no field.
// - A pin with one peripheral function connects to it directly.
// - A pin-routed input with no pin feeding it receives a constant level.
package pss_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] FIRST_SEL_OFFSET = 8'h10;
  localparam logic [7:0] SECOND_SEL_OFFSET = 8'h11;

  // Register widths and reset values
  localparam int REG_W = 16;
  localparam int FIRST_USED_W = 12;
  localparam logic [15:0] FIRST_SEL_RESET = 16'h0000;
  localparam logic [15:0] SECOND_SEL_RESET = 16'h0000;

  // Field positions in the first select register
  localparam int FAULT1_BIT = 9;
  localparam int FAULT2_BIT = 10;
  localparam int PWM_FAULT_INPUT_THREE_BIT = 11;
  localparam int PWM_EXTERNAL_SOURCE_INPUT_W = 3;
  localparam int PSRC0_LSB = 0;
  localparam int PSRC1_LSB = 3;
  localparam int PSRC2_LSB = 6;

  // Fault source encodings
  localparam logic FAULT_FROM_PIN = 1'b0;
  localparam logic FAULT_FROM_CMP = 1'b1;

  // PWM source codes
  localparam logic [2:0] PWM_EXTERNAL_SOURCE_INPUT_CMP_A = 3'h0;
  localparam logic [2:0] PWM_EXTERNAL_SOURCE_INPUT_CMP_B = 3'h1;
  localparam logic [2:0] PWM_EXTERNAL_SOURCE_INPUT_CMP_C = 3'h2;
  localparam logic [2:0] PWM_EXTERNAL_SOURCE_INPUT_TMR_A = 3'h3;
  localparam logic [2:0] PWM_EXTERNAL_SOURCE_INPUT_TMR_B = 3'h4;

  // Levels applied where no source exists
  localparam logic UNFED_LEVEL = 1'b0;
  localparam logic RESERVED_CODE_LEVEL = 1'b0;

  // Number of package pins that feed fault inputs
  localparam int FAULT_PINS = 4;

endpackage

//--- rtl/pss_pin_sync.sv
// Three-stage pin synchroniser whose output moves only when stages two and three agree
module pss_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_clean
);

  // A zero-width synchroniser has nothing to serve
  if (WIDTH < 1) begin : g_bad_width
    $error("pss_pin_sync: WIDTH must be at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_r, mid_r, late_r, clean_r;
    logic meta_nxt, mid_nxt, late_nxt, clean_nxt;

    // Stage one is read only by stage two; the agree test filters single-edge glitches
    always_comb begin
      meta_nxt = pin_async[i];
      mid_nxt = meta_r;
      late_nxt = mid_r;
      clean_nxt = clean_r;
      if (mid_r == late_r) begin
        clean_nxt = late_r;
      end
    end

    // Registers freeze while the clock enable is low
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        meta_r <= 1'b0;
        mid_r <= 1'b0;
        late_r <= 1'b0;
        clean_r <= 1'b0;
      end else if (clock_en) begin
        meta_r <= meta_nxt;
        mid_r <= mid_nxt;
        late_r <= late_nxt;
        clean_r <= clean_nxt;
      end
    end

    assign pin_clean[i] = clean_r;
  end

endmodule

//--- rtl/pss_input_source_select.sv
// Peripheral input source selector: routes pins, comparators and timers into PWM inputs
//
// Implementation choice: the plain strobed port.
module pss_input_source_select #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Package pins able to feed the fault inputs
  input wire logic pin_fault_zero,
  input wire logic pin_fault_one,
  input wire logic pin_fault_two,
  input wire logic pin_fault_three,
  // Pin-function state from the pin mux, index 0 to 3 as fault zero to three
  input wire logic [3:0] pin_function_selected,
  input wire logic [3:0] pin_peripheral_enable,
  // On-chip sources, same clock domain
  input wire logic comparator_a_output,
  input wire logic comparator_b_output,
  input wire logic comparator_c_output,
  input wire logic timer_channel_a_output,
  input wire logic timer_channel_b_output,
  // Routed peripheral inputs
  output logic pwm_fault_input_zero,
  output logic pwm_fault_input_one,
  output logic pwm_fault_input_two,
  output logic pwm_fault_input_three,
  output logic [2:0] pwm_external_source_input,
  // Second select register contents for the comparator and timer input muxes
  output logic [15:0] second_source_select_value
);

  // The highest offset must be reachable by the address port
  if (ADDR_W < 5) begin : g_bad_addr
    $error("pss_input_source_select: ADDR_W must be at least 5");
  end

  // Fault select bits must fit in the stored bits, or they would read back as reserved
  if (pss_pkg::PWM_FAULT_INPUT_THREE_BIT >= pss_pkg::FIRST_USED_W) begin : g_bad_fault_bit
    $error("pss_input_source_select: fault select bit beyond the stored bits");
  end

  // The three PWM source fields must sit below the first fault select bit
  if (pss_pkg::PSRC2_LSB + pss_pkg::PWM_EXTERNAL_SOURCE_INPUT_W > pss_pkg::FAULT1_BIT) begin : g_bad_pwm_external_source_input_field
    $error("pss_input_source_select: PWM source fields overlap the fault bits");
  end

  // The decode function takes three-bit codes
  if (pss_pkg::PWM_EXTERNAL_SOURCE_INPUT_W != 3) begin : g_bad_pwm_external_source_input_w
    $error("pss_input_source_select: PWM source fields must be three bits wide");
  end

  // The read path pads the stored bits with zeros up to the register width
  if (pss_pkg::FIRST_USED_W > pss_pkg::REG_W) begin : g_bad_used_w
    $error("pss_input_source_select: stored bits wider than the register");
  end

  // Reserved bits read as zero, so their reset value must be zero too
  if (pss_pkg::FIRST_SEL_RESET[15:12] != 4'h0) begin : g_bad_reset
    $error("pss_input_source_select: reserved bits must reset to zero");
  end

  // The routing below is written for exactly four fault inputs
  if (pss_pkg::FAULT_PINS != 4) begin : g_bad_fault_pins
    $error("pss_input_source_select: four fault pins expected");
  end

  localparam logic [ADDR_W-1:0] FIRST_ADDR = ADDR_W'(pss_pkg::FIRST_SEL_OFFSET);
  localparam logic [ADDR_W-1:0] SECOND_ADDR = ADDR_W'(pss_pkg::SECOND_SEL_OFFSET);

  // Two registers on one offset would alias each other
  if (FIRST_ADDR == SECOND_ADDR) begin : g_addr_alias
    $error("pss_input_source_select: register offsets collide");
  end

  // Limitation: a select change reaches the routed inputs one clock later,
  // with no interlock against a running PWM; software must quiesce it first.
  // A pin that is not both selected and peripheral-owned reads as the unfed level,
  // so a misconfigured pad never leaks its GPIO value into a fault input.

  // Register state
  logic [pss_pkg::FIRST_USED_W-1:0] first_sel_r, first_sel_nxt;
  logic [15:0] second_sel_r, second_sel_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  // Routed output state
  logic [3:0] fault_r, fault_nxt;
  logic [2:0] pwm_external_source_input_r, pwm_external_source_input_nxt;

  // Filtered pin levels and pin-feed status
  logic [pss_pkg::FAULT_PINS-1:0] pin_raw;
  logic [pss_pkg::FAULT_PINS-1:0] pin_clean;
  logic [pss_pkg::FAULT_PINS-1:0] pin_fed;
  logic [pss_pkg::FAULT_PINS-1:0] pin_level;
  logic [2:0] cmp_out;
  logic [4:0] pwm_external_source_input_sources;

  // Pins come from outside the clock domain
  assign pin_raw = {pin_fault_three, pin_fault_two, pin_fault_one, pin_fault_zero};

  // Three flops plus an agree stage; a fed pin reaches its output five edges late
  pss_pin_sync #(
    .WIDTH(pss_pkg::FAULT_PINS)
  ) i_pss_pin_sync (
    .clock(clock),
    .resetn(resetn),
    .clock_en(clock_en),
    .pin_async(pin_raw),
    .pin_clean(pin_clean)
  );

  // A pin only counts as feeding when the pin mux hands it to the peripheral
  assign pin_fed = pin_function_selected & pin_peripheral_enable;

  // Unfed pins give a fixed inactive level rather than a floating pad value
  always_comb begin
    for (int i = 0; i < pss_pkg::FAULT_PINS; i++) begin
      pin_level[i] = pin_fed[i] ? pin_clean[i] : pss_pkg::UNFED_LEVEL;
    end
  end

  assign cmp_out = {comparator_c_output, comparator_b_output, comparator_a_output};
  assign pwm_external_source_input_sources = {timer_channel_b_output, timer_channel_a_output, cmp_out};

  // Decode of one PWM source code; reserved codes give a fixed level
  // Code order follows pwm_external_source_input_sources: comparators A to C, then timer channels A and B
  function automatic logic pick_pwm_external_source_input(input logic [2:0] code, input logic [4:0] srcs);
    logic v;
    v = pss_pkg::RESERVED_CODE_LEVEL;
    case (code)
      pss_pkg::PWM_EXTERNAL_SOURCE_INPUT_CMP_A: v = srcs[0];
      pss_pkg::PWM_EXTERNAL_SOURCE_INPUT_CMP_B: v = srcs[1];
      pss_pkg::PWM_EXTERNAL_SOURCE_INPUT_CMP_C: v = srcs[2];
      pss_pkg::PWM_EXTERNAL_SOURCE_INPUT_TMR_A: v = srcs[3];
      pss_pkg::PWM_EXTERNAL_SOURCE_INPUT_TMR_B: v = srcs[4];
      default: v = pss_pkg::RESERVED_CODE_LEVEL;
    endcase
    return v;
  endfunction

  // Register writes and read data; read data stand for one cycle only
  always_comb begin
    first_sel_nxt = first_sel_r;
    second_sel_nxt = second_sel_r;
    rdata_nxt = 16'h0000;
    if (reg_write) begin
      if (reg_addr == FIRST_ADDR) begin
        first_sel_nxt = reg_wdata[pss_pkg::FIRST_USED_W-1:0];
      end else if (reg_addr == SECOND_ADDR) begin
        second_sel_nxt = reg_wdata;
      end
    end
    if (reg_read) begin
      case (reg_addr)
        FIRST_ADDR: rdata_nxt = {4'h0, first_sel_r};
        SECOND_ADDR: rdata_nxt = second_sel_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Register file; changing a field under a running peripheral is left to software
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first_sel_r <= pss_pkg::FIRST_SEL_RESET[pss_pkg::FIRST_USED_W-1:0];
      second_sel_r <= pss_pkg::SECOND_SEL_RESET;
      rdata_r <= 16'h0000;
    end else if (clock_en) begin
      first_sel_r <= first_sel_nxt;
      second_sel_r <= second_sel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Source routing for the fault and PWM source inputs
  always_comb begin
    // Fault zero has only one source, its own pin, so it has no select bit
    fault_nxt[0] = pin_level[0];
    // Fault n (1..3) chooses between pin n and comparator n-1
    for (int i = 1; i < 4; i++) begin
      if (first_sel_r[pss_pkg::FAULT1_BIT + i - 1] == pss_pkg::FAULT_FROM_CMP) begin
        fault_nxt[i] = cmp_out[i-1];
      end else begin
        fault_nxt[i] = pin_level[i];
      end
    end
    // Each PWM source input decodes its own 3-bit field
    for (int j = 0; j < 3; j++) begin
      pwm_external_source_input_nxt[j] = pick_pwm_external_source_input(first_sel_r[pss_pkg::PSRC0_LSB + j*pss_pkg::PWM_EXTERNAL_SOURCE_INPUT_W +: 3],
                              pwm_external_source_input_sources);
    end
  end

  // Outputs are registered so consumers never see mux glitches during a field change
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_r <= 4'h0;
      pwm_external_source_input_r <= 3'h0;
    end else if (clock_en) begin
      fault_r <= fault_nxt;
      pwm_external_source_input_r <= pwm_external_source_input_nxt;
    end
  end

  // Register read data
  assign reg_rdata = rdata_r;

  // Routed fault inputs
  assign pwm_fault_input_zero = fault_r[0];
  assign pwm_fault_input_one = fault_r[1];
  assign pwm_fault_input_two = fault_r[2];
  assign pwm_fault_input_three = fault_r[3];

  // Routed PWM source inputs and the exported second register
  assign pwm_external_source_input = pwm_external_source_input_r;
  assign second_source_select_value = second_sel_r;

endmodule

//--- sim/pss_source_model.sv
// Behavioural comparators and timers on the far side of the selector
module pss_source_model (
  input wire logic clock,
  input wire logic resetn,
  output logic [4:0] src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r;
  // Mixed count bits keep the five sources apart, so a wrong pick shows
  // No PWM is modelled, so select changes never hit a running peripheral
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) cnt_r <= 5'h00;
    else cnt_r <= cnt_r + 5'h01;
  end
  assign src = {cnt_r[0] ^ cnt_r[3], cnt_r[2], cnt_r[1] ^ cnt_r[4], cnt_r[1], cnt_r[0]};
endmodule

//--- sim/pss_select_sva.sv
// Port assertions for the input source selector
module pss_select_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic pin_fault_zero,
  input wire logic [3:0] pin_function_selected,
  input wire logic [3:0] pin_peripheral_enable,
  input wire logic comparator_a_output,
  input wire logic comparator_b_output,
  input wire logic comparator_c_output,
  input wire logic timer_channel_a_output,
  input wire logic timer_channel_b_output,
  input wire logic pwm_fault_input_zero,
  input wire logic pwm_fault_input_three,
  input wire logic [2:0] pwm_external_source_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] sel_r, sel_nxt;
  logic [4:0] src;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  assign src = {timer_channel_b_output, timer_channel_a_output, comparator_c_output,
    comparator_b_output, comparator_a_output};
  // Shadow of the used select bits, so routing is judged from the ports alone
  always_comb begin
    sel_nxt = sel_r;
    if (clock_en && reg_write && reg_addr == 8'h10) sel_nxt = reg_wdata[11:0];
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) sel_r <= 12'h000;
    else sel_r <= sel_nxt;
  end
  function automatic logic pick(input logic [2:0] code, input logic [4:0] s);
    pick = (code < 3'h5) ? s[code] : 1'b0;
  endfunction
  // Six stable cycles cover the pin filter latency with margin
  sequence s_unfed_three;
    clock_en && !sel_r[11] && !(pin_function_selected[3] && pin_peripheral_enable[3]);
  endsequence
  sequence s_fed_zero_high;
    clock_en && pin_function_selected[0] && pin_peripheral_enable[0] && pin_fault_zero;
  endsequence
  property p_fault_cmp;
    clock_en && sel_r[11] |=> pwm_fault_input_three == $past(comparator_c_output);
  endproperty
  a_fault_cmp: assert property (p_fault_cmp) else $error("fault three route wrong");
  property p_pwm_external_source_input;
    clock_en |=> pwm_external_source_input == $past({pick(sel_r[8:6], src),
      pick(sel_r[5:3], src), pick(sel_r[2:0], src)});
  endproperty
  a_pwm_external_source_input: assert property (p_pwm_external_source_input) else $error("pwm source route wrong");
  property p_fault_zero;
    s_fed_zero_high [*6] |=> pwm_fault_input_zero;
  endproperty
  a_fault_zero: assert property (p_fault_zero)
    else $error("fault zero pin lost");
  property p_unfed;
    s_unfed_three [*6] |=> !pwm_fault_input_three;
  endproperty
  a_unfed: assert property (p_unfed) else $error("unfed input not constant");
  property p_rd;
    clock_en && reg_read && reg_addr == 8'h10 |=> reg_rdata == {4'h0, $past(sel_r)};
  endproperty
  a_rd: assert property (p_rd) else $error("select read value wrong");
  property p_idle;
    clock_en && !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
endmodule

bind pss_input_source_select pss_select_sva #(
  .ADDR_W(ADDR_W)
) i_pss_select_sva (
  .clock(clock),
  .resetn(resetn),
  .clock_en(clock_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .pin_fault_zero(pin_fault_zero),
  .pin_function_selected(pin_function_selected),
  .pin_peripheral_enable(pin_peripheral_enable),
  .comparator_a_output(comparator_a_output),
  .comparator_b_output(comparator_b_output),
  .comparator_c_output(comparator_c_output),
  .timer_channel_a_output(timer_channel_a_output),
  .timer_channel_b_output(timer_channel_b_output),
  .pwm_fault_input_zero(pwm_fault_input_zero),
  .pwm_fault_input_three(pwm_fault_input_three),
  .pwm_external_source_input(pwm_external_source_input)
);

//--- sim/peripheral_input_source_select_test.sv
// Self-checking bench for the peripheral input source selector
module peripheral_input_source_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, clock_en, reg_write, reg_read;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, second_source_select_value;
  logic [3:0] pins, pin_function_selected, pin_peripheral_enable;
  logic [4:0] src;
  logic pwm_fault_input_zero, pwm_fault_input_one, pwm_fault_input_two, pwm_fault_input_three;
  logic [2:0] pwm_external_source_input;
  wire pin_fault_zero = pins[0], pin_fault_one = pins[1], pin_fault_two = pins[2],
    pin_fault_three = pins[3];
  wire comparator_a_output = src[0], comparator_b_output = src[1], comparator_c_output = src[2],
    timer_channel_a_output = src[3], timer_channel_b_output = src[4];
  wire [3:0] fault = {pwm_fault_input_three, pwm_fault_input_two, pwm_fault_input_one,
    pwm_fault_input_zero};
  int fail_count, cmp_count;
  pss_source_model i_pss_source_model (.clock(clock), .resetn(resetn), .src(src));
  pss_input_source_select i_pss_input_source_select (
    .clock(clock),
    .resetn(resetn),
    .clock_en(clock_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .pin_fault_zero(pin_fault_zero),
    .pin_fault_one(pin_fault_one),
    .pin_fault_two(pin_fault_two),
    .pin_fault_three(pin_fault_three),
    .pin_function_selected(pin_function_selected),
    .pin_peripheral_enable(pin_peripheral_enable),
    .comparator_a_output(comparator_a_output),
    .comparator_b_output(comparator_b_output),
    .comparator_c_output(comparator_c_output),
    .timer_channel_a_output(timer_channel_a_output),
    .timer_channel_b_output(timer_channel_b_output),
    .pwm_fault_input_zero(pwm_fault_input_zero),
    .pwm_fault_input_one(pwm_fault_input_one),
    .pwm_fault_input_two(pwm_fault_input_two),
    .pwm_fault_input_three(pwm_fault_input_three),
    .pwm_external_source_input(pwm_external_source_input),
    .second_source_select_value(second_source_select_value)
  );
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles start just after a rising edge and end on one
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp);
    @(posedge clock);
  endtask
  task automatic t_regs();
    rd(8'h10, 16'h0000);
    wr(8'h10, 16'hffff);
    rd(8'h10, 16'h0fff);
    wr(8'h11, 16'ha5c3);
    rd(8'h11, 16'ha5c3);
    chk(second_source_select_value, 16'ha5c3);
    rd(8'h20, 16'h0000);
  endtask
  // Pins stay low and unfed here, so a fault input on pin routing must read 0
  task automatic t_route(input logic [2:0] code);
    logic [4:0] prev;
    wr(8'h10, {4'h0, {4{code}}});
    @(posedge clock);
    @(negedge clock);
    prev = src;
    // Every cycle is checked, so the sources that toggle each cycle are seen both ways
    repeat (12) begin
      @(negedge clock);
      chk({13'h0000, pwm_external_source_input},
        {13'h0000, {3{code < 3'h5 ? prev[code] : 1'b0}}});
      chk({12'h000, fault}, {12'h000, code & prev[2:0], 1'b0});
      prev = src;
    end
    @(posedge clock);
  endtask
  task automatic t_pins();
    wr(8'h10, 16'h0000);
    pin_function_selected <= 4'hf;
    pin_peripheral_enable <= 4'hf;
    pins <= 4'hf;
    repeat (8) @(negedge clock);
    chk({12'h000, fault}, 16'h000f);
    @(posedge clock);
    pin_peripheral_enable <= 4'h5;
    repeat (8) @(negedge clock);
    chk({12'h000, fault}, 16'h0005);
    @(posedge clock);
  endtask
  // A low clock enable ignores strobes and holds every output
  task automatic t_freeze();
    logic [2:0] held;
    wr(8'h10, 16'h0000);
    clock_en <= 1'b0;
    @(negedge clock);
    held = pwm_external_source_input;
    @(negedge clock);
    chk({13'h0000, pwm_external_source_input}, {13'h0000, held});
    @(posedge clock);
    wr(8'h11, 16'h5a5a);
    clock_en <= 1'b1;
    rd(8'h11, 16'ha5c3);
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    clock_en = 1'b1;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {pins, pin_function_selected, pin_peripheral_enable} = 12'h000;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_regs();
    for (int c = 0; c < 8; c++) t_route(3'(c));
    t_pins();
    t_freeze();
    results();
  end
  // The run needs about 170 cycles; 2000 means a hang
  initial begin
    #80000;
    fail_count++;
    $display("ERROR at %0t: run still busy, got %h expected %h", $time, 1'b1, 1'b0);
    results();
  end
endmodule
